/* core/sfwp_pkg.sv */
// package: constants, opcodes and carriers for the flash write-protection block
// Contract
// - power-up starts idle, nothing pending
// - changes only after complete valid sequence
// - command length must end on byte
// - write-enable latch required before data changes
// - latch clears: power-up, write disable, status write
// - latch clears after program and all erases
// - latch clears: suspend, soft reset, security write
// - deep sleep accepts only wake, reset enable, reset
// - protected region rejects program and erase
// - levels 0..3 protect 0,2,4,8 top blocks
// - levels 4..6 protect 16,32,64 top blocks
// - level 7 and msb set protect all
// - protect pin guards level and srwd bits
// - quad modes disable hardware protect mode
// - security bit 1 reports otp lock
// - otp lock settable once, never cleared
// - otp mode entered, programmed, exited; array blocked
// - otp area 4096 bits, low address 000-1ff
// - non-read command needs byte-aligned deselect
// - array access ignored while busy
package sfwp_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD_C = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD_C = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE_CMD_C = 8'h01;
  localparam logic [7:0] OP_PP_C = 8'h02;
  localparam logic [7:0] OP_QPP_C = 8'h38;
  localparam logic [7:0] OP_SE_C = 8'h20;
  localparam logic [7:0] OP_BE32_C = 8'h52;
  localparam logic [7:0] OP_BE64_C = 8'hd8;
  localparam logic [7:0] OP_CE_C = 8'hc7;
  localparam logic [7:0] OP_CE2_C = 8'h60;
  localparam logic [7:0] OP_DP_C = 8'hb9;
  localparam logic [7:0] OP_WAKE_C = 8'hab;
  localparam logic [7:0] OP_ENSO_C = 8'hb1;
  localparam logic [7:0] OP_EXSO_C = 8'hc1;
  localparam logic [7:0] OP_SECURITY_REG_WRITE_CMD_C = 8'h2f;
  localparam logic [7:0] OP_SUSP_C = 8'hb0;
  localparam logic [7:0] OP_RSTEN_C = 8'h66;
  localparam logic [7:0] OP_RST_C = 8'h99;
  localparam logic [7:0] OP_EQIO_C = 8'h35;
  localparam logic [7:0] OP_RSTQIO_C = 8'hf5;
  // status byte fields
  localparam int SR_BP_LSB_C = 2;
  localparam int SR_SRWD_C = 7;
  // security register field
  localparam int SCUR_LOCK_C = 1;
  localparam int BLK_MSB_C = 22;
  localparam int BLK_LSB_C = 16;
  localparam logic [6:0] BLK_TOP_C = 7'h7f;
  localparam logic [23:0] OTP_LAST_C = 24'h0001ff;
  localparam logic [3:0] BP_RESET_C = 4'h0;
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] data;
    logic has_addr;
    logic has_data;
    logic [5:0] bit_count;
  } sfwp_cmd_t;
  typedef enum logic [1:0] {
    SFWP_IDLE, SFWP_BUSY, SFWP_SLEEP
  } sfwp_state_t;
endpackage : sfwp_pkg

/* core/sfwp_top.sv */
// flash write-protection, latch and otp control
`timescale 1ns/1ps
`default_nettype none
module sfwp_top (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic cmd_valid_in,
  input wire sfwp_pkg::sfwp_cmd_t cmd_in,
  input wire logic wp_n_in,
  input wire logic quad_io_in,
  input wire logic op_done_in,
  output logic exec_out,
  output logic [7:0] exec_op_out,
  output logic [23:0] exec_addr_out,
  output logic reject_out,
  output logic write_enable_latch_out,
  output logic [7:0] status_out,
  output logic [7:0] security_out,
  output logic otp_mode_out,
  output logic quad_command_mode_out,
  output logic sleep_out,
  output logic busy_out
);
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;
  sfwp_pkg::sfwp_state_t state_ff;
  logic wel_ff;
  logic [3:0] bp_ff;
  logic srwd_ff;
  logic lock_ff;
  logic otp_ff;
  logic qpi_ff;
  logic rsten_ff;
  logic [7:0] pend_op_ff;
  logic exec_ff;
  logic [7:0] exec_op_ff;
  logic [23:0] exec_addr_ff;
  logic reject_ff;
  logic [7:0] op;
  logic aligned;
  logic len_ok;
  logic is_write;
  logic prot_hit;
  logic hw_lock;
  logic accept;
  logic start_op;
  logic [6:0] blk;
  logic [6:0] low_blk;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // lowest protected block for a level; 0 means none via separate check
  function automatic logic [6:0] sfwp_low_blk(input logic [3:0] lvl);
    logic [6:0] r;
    r = 7'h00;
    if (lvl[3] || lvl == 4'h7) begin
      r = 7'h00;
    end else begin
      unique case (lvl[2:0])
        3'h1: r = 7'h7e;
        3'h2: r = 7'h7c;
        3'h3: r = 7'h78;
        3'h4: r = 7'h70;
        3'h5: r = 7'h60;
        3'h6: r = 7'h40;
        default: r = sfwp_pkg::BLK_TOP_C;
      endcase
    end
    return r;
  endfunction : sfwp_low_blk

  function automatic logic sfwp_is_op(input logic [7:0] o,
                                      input logic [7:0] ref_op);
    return o == ref_op;
  endfunction : sfwp_is_op

  assign op = cmd_in.opcode;
  assign aligned = (cmd_in.bit_count[2:0] == 3'h0);
  // non-read needs alignment; length must cover the opcode and any address, the data byte is not length-checked
  assign len_ok = aligned && (cmd_in.bit_count >= 6'h08) &&
                  (!cmd_in.has_addr || cmd_in.bit_count >= 6'h20);
  assign is_write = sfwp_is_op(op, sfwp_pkg::OP_PP_C) ||
                    sfwp_is_op(op, sfwp_pkg::OP_QPP_C) ||
                    sfwp_is_op(op, sfwp_pkg::OP_SE_C) ||
                    sfwp_is_op(op, sfwp_pkg::OP_BE32_C) ||
                    sfwp_is_op(op, sfwp_pkg::OP_BE64_C) ||
                    sfwp_is_op(op, sfwp_pkg::OP_CE_C) ||
                    sfwp_is_op(op, sfwp_pkg::OP_CE2_C);
  assign blk = cmd_in.addr[sfwp_pkg::BLK_MSB_C:sfwp_pkg::BLK_LSB_C];
  assign low_blk = sfwp_low_blk(bp_ff);
  always_comb begin
    prot_hit = 1'b0;
    if (otp_ff) begin
      // locked otp refuses program; otp range
      // upper address digits are don't-care, the low twelve bits are not
      prot_hit = lock_ff ||
                 (cmd_in.addr[11:0] > sfwp_pkg::OTP_LAST_C[11:0]);
      // no erase of array in otp mode
      if (!sfwp_is_op(op, sfwp_pkg::OP_PP_C) &&
          !sfwp_is_op(op, sfwp_pkg::OP_QPP_C)) begin
        prot_hit = 1'b1;
      end
    end else if (bp_ff != sfwp_pkg::BP_RESET_C) begin
      if (sfwp_is_op(op, sfwp_pkg::OP_CE_C) ||
          sfwp_is_op(op, sfwp_pkg::OP_CE2_C)) begin
        prot_hit = 1'b1;
      end else begin
        prot_hit = (blk >= low_blk);
      end
    end
  end
  assign hw_lock = srwd_ff && !wp_n_in && !qpi_ff && !quad_io_in;

  // acceptance only on full valid frame
  always_comb begin
    accept = 1'b0;
    if (cmd_valid_in && len_ok) begin
      unique case (state_ff)
        sfwp_pkg::SFWP_IDLE: begin
          accept = 1'b1;
          if ((is_write || sfwp_is_op(op, sfwp_pkg::OP_STATUS_WRITE_CMD_C) ||
               sfwp_is_op(op, sfwp_pkg::OP_SECURITY_REG_WRITE_CMD_C)) && !wel_ff) begin
            accept = 1'b0;
          end
          if (is_write && prot_hit) begin
            accept = 1'b0;
          end
          if (sfwp_is_op(op, sfwp_pkg::OP_STATUS_WRITE_CMD_C) &&
              (hw_lock || !cmd_in.has_data)) begin
            accept = 1'b0;
          end
          if (sfwp_is_op(op, sfwp_pkg::OP_SECURITY_REG_WRITE_CMD_C) && lock_ff) begin
            accept = 1'b0;
          end
        end
        sfwp_pkg::SFWP_BUSY: begin
          accept = sfwp_is_op(op, sfwp_pkg::OP_SUSP_C);
        end
        sfwp_pkg::SFWP_SLEEP: begin
          accept = sfwp_is_op(op, sfwp_pkg::OP_WAKE_C) ||
                   sfwp_is_op(op, sfwp_pkg::OP_RSTEN_C) ||
                   sfwp_is_op(op, sfwp_pkg::OP_RST_C);
        end
      endcase
    end
  end
  assign start_op = accept && (state_ff == sfwp_pkg::SFWP_IDLE) &&
                    (is_write || sfwp_is_op(op, sfwp_pkg::OP_STATUS_WRITE_CMD_C) ||
                     sfwp_is_op(op, sfwp_pkg::OP_SECURITY_REG_WRITE_CMD_C));
  logic soft_rst;
  assign soft_rst = accept && sfwp_is_op(op, sfwp_pkg::OP_RST_C) && rsten_ff;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= sfwp_pkg::SFWP_IDLE;
      pend_op_ff <= 8'h00;
    end else if (soft_rst) begin
      state_ff <= sfwp_pkg::SFWP_IDLE;
    end else begin
      unique case (state_ff)
        sfwp_pkg::SFWP_IDLE: begin
          if (start_op) begin
            state_ff <= sfwp_pkg::SFWP_BUSY;
            pend_op_ff <= op;
          end else if (accept && sfwp_is_op(op, sfwp_pkg::OP_DP_C)) begin
            state_ff <= sfwp_pkg::SFWP_SLEEP;
          end
        end
        sfwp_pkg::SFWP_BUSY: begin
          if (op_done_in || accept) begin
            state_ff <= sfwp_pkg::SFWP_IDLE;
          end
        end
        sfwp_pkg::SFWP_SLEEP: begin
          if (accept && sfwp_is_op(op, sfwp_pkg::OP_WAKE_C)) begin
            state_ff <= sfwp_pkg::SFWP_IDLE;
          end
        end
      endcase
    end
  end

  // write-enable latch
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wel_ff <= 1'b0;
    end else if (soft_rst) begin
      wel_ff <= 1'b0;
    end else if (state_ff == sfwp_pkg::SFWP_BUSY && (op_done_in || accept)) begin
      wel_ff <= 1'b0;
    end else if (accept && state_ff == sfwp_pkg::SFWP_IDLE) begin
      if (sfwp_is_op(op, sfwp_pkg::OP_WRITE_ENABLE_CMD_C)) begin
        wel_ff <= 1'b1;
      end else if (sfwp_is_op(op, sfwp_pkg::OP_WRITE_DISABLE_CMD_C)) begin
        wel_ff <= 1'b0;
      end
    end
  end

  // status bits update when the write completes, not when issued
  logic [7:0] wr_data_ff;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_data_ff <= 8'h00;
    end else if (start_op) begin
      wr_data_ff <= cmd_in.data;
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bp_ff <= sfwp_pkg::BP_RESET_C;
      srwd_ff <= 1'b0;
    end else if (state_ff == sfwp_pkg::SFWP_BUSY && op_done_in &&
                 pend_op_ff == sfwp_pkg::OP_STATUS_WRITE_CMD_C) begin
      bp_ff <= wr_data_ff[sfwp_pkg::SR_BP_LSB_C +: 4];
      srwd_ff <= wr_data_ff[sfwp_pkg::SR_SRWD_C];
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= 1'b0;
    end else if (state_ff == sfwp_pkg::SFWP_BUSY && op_done_in &&
                 pend_op_ff == sfwp_pkg::OP_SECURITY_REG_WRITE_CMD_C) begin
      lock_ff <= 1'b1;
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      otp_ff <= 1'b0;
    end else if (soft_rst) begin
      otp_ff <= 1'b0;
    end else if (accept && state_ff == sfwp_pkg::SFWP_IDLE) begin
      if (sfwp_is_op(op, sfwp_pkg::OP_ENSO_C)) begin
        otp_ff <= 1'b1;
      end else if (sfwp_is_op(op, sfwp_pkg::OP_EXSO_C)) begin
        otp_ff <= 1'b0;
      end
    end
  end
  // quad command mode and reset-enable arming
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      qpi_ff <= 1'b0;
      rsten_ff <= 1'b0;
    end else if (soft_rst) begin
      qpi_ff <= 1'b0;
      rsten_ff <= 1'b0;
    end else if (accept) begin
      rsten_ff <= sfwp_is_op(op, sfwp_pkg::OP_RSTEN_C);
      if (state_ff == sfwp_pkg::SFWP_IDLE &&
          sfwp_is_op(op, sfwp_pkg::OP_EQIO_C)) begin
        qpi_ff <= 1'b1;
      end else if (state_ff == sfwp_pkg::SFWP_IDLE &&
                   sfwp_is_op(op, sfwp_pkg::OP_RSTQIO_C)) begin
        qpi_ff <= 1'b0;
      end
    end else if (cmd_valid_in) begin
      rsten_ff <= 1'b0;
    end
  end
  // execution and reject pulses
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      exec_ff <= 1'b0;
      exec_op_ff <= 8'h00;
      exec_addr_ff <= 24'h000000;
      reject_ff <= 1'b0;
    end else begin
      exec_ff <= accept;
      reject_ff <= cmd_valid_in && !accept;
      if (accept) begin
        exec_op_ff <= op;
        exec_addr_ff <= cmd_in.addr;
      end
    end
  end

  assign exec_out = exec_ff;
  assign exec_op_out = exec_op_ff;
  assign exec_addr_out = exec_addr_ff;
  assign reject_out = reject_ff;
  assign write_enable_latch_out = wel_ff;
  assign security_out = {6'h00, lock_ff, 1'b0};
  assign status_out = {srwd_ff, 1'b0, bp_ff, wel_ff,
                       state_ff == sfwp_pkg::SFWP_BUSY};
  assign otp_mode_out = otp_ff;
  assign quad_command_mode_out = qpi_ff;
  assign sleep_out = state_ff == sfwp_pkg::SFWP_SLEEP;
  assign busy_out = state_ff == sfwp_pkg::SFWP_BUSY;
endmodule : sfwp_top
`default_nettype wire

/* verif/sfwp_properties.sv */
// checker: port-level rules of the write-protection block
`timescale 1ns/1ps
`default_nettype none
module sfwp_properties (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic cmd_valid_in,
  input wire sfwp_pkg::sfwp_cmd_t cmd_in,
  input wire logic wp_n_in,
  input wire logic quad_io_in,
  input wire logic op_done_in,
  input wire logic exec_out,
  input wire logic reject_out,
  input wire logic write_enable_latch_out,
  input wire logic [7:0] status_out,
  input wire logic [7:0] security_out,
  input wire logic quad_command_mode_out,
  input wire logic sleep_out,
  input wire logic busy_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  logic fr;
  logic [7:0] op;
  assign fr = cmd_valid_in;
  assign op = cmd_in.opcode;
  sequence s_taken(logic [7:0] o);
    fr && op == o ##1 exec_out;
  endsequence
  chk_answer_once: assert property (fr |=> exec_out != reject_out)
    else $error("frame not answered once");
  chk_whole_bytes: assert property (fr && cmd_in.bit_count[2:0] != 3'h0
    |=> reject_out) else $error("partial byte accepted");
  chk_latch_gate: assert property (fr && op == sfwp_pkg::OP_PP_C
    && !write_enable_latch_out |=> reject_out) else $error("no latch");
  chk_latch_sets: assert property (s_taken(sfwp_pkg::OP_WRITE_ENABLE_CMD_C)
    |-> write_enable_latch_out) else $error("latch not set");
  chk_disable_clears: assert property (s_taken(sfwp_pkg::OP_WRITE_DISABLE_CMD_C)
    |-> !write_enable_latch_out) else $error("latch not cleared");
  chk_done_clears: assert property (busy_out && op_done_in
    |=> !write_enable_latch_out && !busy_out) else $error("done left latch");
  chk_sleep_filter: assert property (sleep_out && fr
    && !(op inside {8'hab, 8'h66, 8'h99}) |=> reject_out)
    else $error("sleep let command in");
  chk_pin_guard: assert property (fr && op == sfwp_pkg::OP_STATUS_WRITE_CMD_C
    && status_out[7] && !wp_n_in && !quad_io_in && !quad_command_mode_out
    |=> reject_out) else $error("pin guard open");
  chk_otp_sticky: assert property (security_out[1]
    |=> security_out[1] [*3]) else $error("otp lock cleared");
  chk_busy_refuse: assert property (busy_out && fr
    && op != sfwp_pkg::OP_SUSP_C |=> reject_out) else $error("busy took");
  chk_chip_guard: assert property (fr && op == sfwp_pkg::OP_CE_C
    && status_out[5:2] != 4'h0 |=> reject_out) else $error("chip erase");
endmodule : sfwp_properties
bind sfwp_top sfwp_properties sfwp_properties_i (.core_clk_in, .nrst_in,
  .cmd_valid_in, .cmd_in, .wp_n_in, .quad_io_in, .op_done_in, .exec_out,
  .reject_out, .write_enable_latch_out, .status_out, .security_out,
  .quad_command_mode_out, .sleep_out, .busy_out);
`default_nettype wire

/* verif/sfwp_host.sv */
// host model: hands whole decoded frames to the block
`timescale 1ns/1ps
`default_nettype none
module sfwp_host (
  input wire logic clk_in,
  output var logic cmd_valid_out,
  output var sfwp_pkg::sfwp_cmd_t cmd_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end
  task automatic frame(input logic [7:0] op, input logic [23:0] a,
                       input logic [7:0] d, input logic [5:0] n);
    @(posedge clk_in);
    #1;
    cmd_out = {op, a, d, n > 6'd16, n == 6'd16 || n > 6'd32, n};
    cmd_valid_out = 1'b1;
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b0;
    // idle lines carry the bitwise inverse of the last frame
    cmd_out = ~cmd_out;
  endtask : frame
endmodule : sfwp_host
`default_nettype wire

/* verif/tb_top.sv */
// bench: latch, protect decode, sleep, pin guard and otp
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic dn = 1'b0;
  logic wp_n = 1'b1;
  logic qio = 1'b0;
  logic cv, ex, rj, write_enable_latch, otp, slp, bsy, qcm;
  logic [7:0] eop;
  logic [23:0] ead;
  logic [7:0] st, sec;
  logic [31:0] r;
  sfwp_pkg::sfwp_cmd_t cmd;
  logic [7:0] ops [5];
  int n_fail = 0;
  int tests_run = 0;
  int b;
  int v;
  always #10 clk = ~clk;
  sfwp_host sfwp_host_i (.clk_in(clk), .cmd_valid_out(cv), .cmd_out(cmd));
  sfwp_top sfwp_top_i (.core_clk_in(clk), .nrst_in(nrst), .cmd_valid_in(cv),
    .cmd_in(cmd), .wp_n_in(wp_n), .quad_io_in(qio), .op_done_in(dn),
    .exec_out(ex), .exec_op_out(eop), .exec_addr_out(ead), .reject_out(rj),
    .write_enable_latch_out(write_enable_latch), .status_out(st), .security_out(sec),
    .otp_mode_out(otp), .quad_command_mode_out(qcm), .sleep_out(slp),
    .busy_out(bsy));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("compares %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic cmd_do(input logic [7:0] op, input logic [23:0] a,
                        input logic [7:0] d, input logic [5:0] n,
                        input logic acc);
    sfwp_host_i.frame(op, a, d, n);
    chk({6'h0, ex, rj}, {6'h0, acc, !acc});
  endtask : cmd_do
  task automatic cmd8(input logic [7:0] op, input logic acc);
    cmd_do(op, 24'h0, 8'h0, 6'd8, acc);
  endtask : cmd8
  task automatic adr(input logic [7:0] op, input logic [23:0] a,
                     input logic acc);
    cmd_do(op, a, 8'h5a, (op == sfwp_pkg::OP_PP_C) ? 6'd40 : 6'd32, acc);
  endtask : adr
  task automatic write_enable_cmd();
    cmd8(sfwp_pkg::OP_WRITE_ENABLE_CMD_C, 1'b1);
  endtask : write_enable_cmd
  task automatic fin();
    @(posedge clk);
    #1 dn = 1'b1;
    @(posedge clk);
    #1 dn = 1'b0;
  endtask : fin
  task automatic setsr(input logic [7:0] d);
    write_enable_cmd();
    cmd_do(sfwp_pkg::OP_STATUS_WRITE_CMD_C, 24'h0, d, 6'd16, 1'b1);
    fin();
  endtask : setsr
  // blocks protected at the top of the array for a level
  function automatic int prot_n(input int lv);
    return (lv > 6) ? 128 : (lv == 0) ? 0 : (1 << lv);
  endfunction : prot_n
  initial begin
    ops = '{sfwp_pkg::OP_PP_C, sfwp_pkg::OP_SE_C, sfwp_pkg::OP_BE32_C,
            sfwp_pkg::OP_BE64_C, sfwp_pkg::OP_CE_C};
    void'($urandom(32'h3a652cc9));
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({write_enable_latch, bsy, slp, otp, sec[1], st[2:0]}, 8'h00);
    adr(sfwp_pkg::OP_PP_C, 24'h0, 1'b0);
    cmd_do(sfwp_pkg::OP_WRITE_ENABLE_CMD_C, 24'h0, 8'h0, 6'd7, 1'b0);
    cmd_do(sfwp_pkg::OP_WRITE_ENABLE_CMD_C, 24'h0, 8'h0, 6'd12, 1'b0);
    chk({7'h0, write_enable_latch}, 8'h00);
    write_enable_cmd();
    cmd8(sfwp_pkg::OP_WRITE_DISABLE_CMD_C, 1'b1);
    chk({7'h0, write_enable_latch}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      write_enable_cmd();
      r = $urandom;
      if (i == 4) cmd8(ops[i], 1'b1);
      else adr(ops[i], r[23:0], 1'b1);
      cmd8(sfwp_pkg::OP_WRITE_ENABLE_CMD_C, 1'b0);
      fin();
      chk({6'h0, write_enable_latch, bsy}, 8'h00);
    end
    write_enable_cmd();
    adr(sfwp_pkg::OP_SE_C, 24'h0, 1'b1);
    cmd8(sfwp_pkg::OP_SUSP_C, 1'b1);
    chk({6'h0, write_enable_latch, bsy}, 8'h00);
    write_enable_cmd();
    cmd8(sfwp_pkg::OP_RSTEN_C, 1'b1);
    cmd8(sfwp_pkg::OP_RST_C, 1'b1);
    chk({7'h0, write_enable_latch}, 8'h00);
    for (v = 0; v < 16; v++) begin
      setsr({2'h0, v[3:0], 2'h0});
      chk({4'h0, st[5:2]}, {4'h0, v[3:0]});
      b = (v == 0) ? 127 : 128 - prot_n(v);
      repeat (2) begin
        write_enable_cmd();
        adr(sfwp_pkg::OP_PP_C, {1'b0, b[6:0], 16'h0},
            b < 128 - prot_n(v));
        if (ex) fin();
        b = $urandom_range(127, 0);
      end
      write_enable_cmd();
      cmd8(sfwp_pkg::OP_CE_C, v == 0);
      if (ex) fin();
    end
    setsr(8'h80);
    wp_n = 1'b0;
    write_enable_cmd();
    cmd_do(sfwp_pkg::OP_STATUS_WRITE_CMD_C, 24'h0, 8'h00, 6'd16, 1'b0);
    cmd8(sfwp_pkg::OP_EQIO_C, 1'b1);
    chk({7'h0, qcm}, 8'h01);
    cmd_do(sfwp_pkg::OP_STATUS_WRITE_CMD_C, 24'h0, 8'h80, 6'd16, 1'b1);
    fin();
    cmd8(sfwp_pkg::OP_RSTQIO_C, 1'b1);
    chk({7'h0, qcm}, 8'h00);
    write_enable_cmd();
    qio = 1'b1;
    cmd_do(sfwp_pkg::OP_STATUS_WRITE_CMD_C, 24'h0, 8'h00, 6'd16, 1'b1);
    fin();
    chk({7'h0, st[7]}, 8'h00);
    qio = 1'b0;
    wp_n = 1'b1;
    cmd8(sfwp_pkg::OP_DP_C, 1'b1);
    cmd8(sfwp_pkg::OP_WRITE_ENABLE_CMD_C, 1'b0);
    cmd8(sfwp_pkg::OP_WAKE_C, 1'b1);
    chk({7'h0, slp}, 8'h00);
    write_enable_cmd();
    cmd8(sfwp_pkg::OP_ENSO_C, 1'b1);
    chk({7'h0, otp}, 8'h01);
    adr(sfwp_pkg::OP_SE_C, 24'h0, 1'b0);
    adr(sfwp_pkg::OP_PP_C, sfwp_pkg::OTP_LAST_C, 1'b1);
    chk(eop, sfwp_pkg::OP_PP_C);
    chk(ead[7:0], 8'hff);
    chk(ead[15:8], 8'h01);
    fin();
    cmd8(sfwp_pkg::OP_EXSO_C, 1'b1);
    chk({7'h0, otp}, 8'h00);
    write_enable_cmd();
    cmd8(sfwp_pkg::OP_ENSO_C, 1'b1);
    adr(sfwp_pkg::OP_PP_C, 24'h000200, 1'b0);
    cmd8(sfwp_pkg::OP_EXSO_C, 1'b1);
    write_enable_cmd();
    cmd8(sfwp_pkg::OP_SECURITY_REG_WRITE_CMD_C, 1'b1);
    fin();
    chk({6'h0, write_enable_latch, sec[1]}, 8'h01);
    write_enable_cmd();
    cmd8(sfwp_pkg::OP_ENSO_C, 1'b1);
    adr(sfwp_pkg::OP_PP_C, 24'h0, 1'b0);
    cmd8(sfwp_pkg::OP_EXSO_C, 1'b1);
    chk({7'h0, sec[1]}, 8'h01);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
